// ### pkg/idn_if.sv
// Carrier between the decode stage and its address generator
`default_nettype none

interface idn_addr_if;
    import idn_pkg::*;

    logic [1:`IDN_OP_W] opcode;
    idn_class_t cls;
    logic dbl_key;
    logic short_fmt;
    logic force_upper;
    logic dbl_precision_key_low;
    logic gated_op_bit13;
    logic gated_op_bit14;
    logic tag_modifier_nonzero;
    logic [`IDN_ADDR_W-1:0] table_addr;

    modport gen (
        input opcode, cls, dbl_key, short_fmt, force_upper,
        output dbl_precision_key_low, gated_op_bit13, gated_op_bit14,
        output tag_modifier_nonzero, table_addr
    );
    modport user (
        output opcode, cls, dbl_key, short_fmt, force_upper,
        input dbl_precision_key_low, gated_op_bit13, gated_op_bit14,
        input tag_modifier_nonzero, table_addr
    );
endinterface : idn_addr_if

`default_nettype wire

// ### pkg/idn_map.svh
// Constants of the instruction decode net: sizes, fields, resets, encodings
`ifndef IDN_MAP_SVH
`define IDN_MAP_SVH

`define IDN_DEPTH 8192
`define IDN_ADDR_W 13
`define IDN_WORD_W 20
`define IDN_ENTRY_W 12
`define IDN_CTL_W 6
`define IDN_PAR_W 2
`define IDN_OP_W 16

// Stored word layout
`define IDN_ENTRY_LSB 0
`define IDN_CTL_LSB 12
`define IDN_PAR_LSB 18
`define IDN_BUS_HALF_W 10

// Reset and fixed values
`define IDN_ENTRY_RST 12'h000
`define IDN_CTL_RST 6'h00
`define IDN_BASE_PB 4'hc
`define IDN_BASE_FLR0 4'h9
`define IDN_BASE_FLR1 4'hb
`define IDN_IDX_Y 3'h5
`define IDN_IDX_X 3'h7
`define IDN_FLR0_SEL 5'h06
`define IDN_FLR1_SEL 5'h0e

`endif

// ### pkg/idn_pkg.sv
// Types shared by the instruction decode net modules
`default_nettype none
`include "idn_map.svh"

package idn_pkg;

    typedef enum logic [2:0] {
        IDN_CLS_GENERIC,
        IDN_CLS_SHIFT,
        IDN_CLS_SKIP,
        IDN_CLS_REG_GENERIC,
        IDN_CLS_SR_MEM,
        IDN_CLS_V_MEM,
        IDN_CLS_I_MEM,
        IDN_CLS_I_SPECIAL
    } idn_class_t;

    typedef enum logic [1:0] {
        IDN_EA_NONE,
        IDN_EA_SRV,
        IDN_EA_I
    } idn_ea_t;

    typedef struct packed {
        logic [1:`IDN_OP_W] opcode_ff;
        idn_class_t cls_ff;
        logic dbl_key_ff;
        logic short_fmt_ff;
        logic mode_32i_ff;
        logic entry_valid_ff;
        logic [`IDN_ENTRY_W-1:0] entry_ff;
        logic [1:`IDN_CTL_W] ctl_ff;
        logic parity_err_ff;
        logic [3:0] base_ff;
        logic [2:0] index_ff;
        idn_ea_t ea_ff;
        logic [2:0] dest_gr_ff;
        logic [2:0] odd_gr_ff;
    } idn_state_t;

endpackage : idn_pkg

`default_nettype wire

// ### src/idn_addr_gen.sv
// Opcode to decode table address mapping, per instruction class
`default_nettype none

module idn_addr_gen
    import idn_pkg::*;
(
    idn_addr_if.gen a
);

    logic [1:`IDN_OP_W] op;
    logic [1:12] bits;

    assign op = a.opcode;
    // RL13: key low active
    assign a.dbl_precision_key_low = ~a.dbl_key;
    // RL12: displacement gating
    assign a.gated_op_bit13 = a.short_fmt ? 1'b0 : op[13];
    assign a.gated_op_bit14 = a.short_fmt ? 1'b0 : op[14];
    // RL11: tag modifier test
    assign a.tag_modifier_nonzero = op[10] | op[11];

    // RL6: fixed class ranges
    always_comb begin
        case (a.cls)
            // RL8: generic mapping
            IDN_CLS_GENERIC: bits = {1'b0, op[2], op[7:16]};
            // RL9: shift, skip, register generic
            IDN_CLS_SHIFT:
                bits = {4'he, op[9:12], op[7:8], op[15:16]};
            IDN_CLS_SKIP:
                bits = {4'ha, op[9:12], op[13:14], op[15:16]};
            IDN_CLS_REG_GENERIC:
                bits = {1'b1, op[2], 2'h3, op[9:12], op[13:16]};
            // RL10: S/R and V memory references
            IDN_CLS_SR_MEM:
                bits = {1'b1, op[2], 1'b0, a.gated_op_bit13,
                        a.gated_op_bit14, a.dbl_precision_key_low, 2'h2,
                        op[6], op[5], ~op[4], ~op[3]};
            IDN_CLS_V_MEM:
                bits = {1'b1, op[2], 1'b0, a.gated_op_bit13,
                        a.gated_op_bit14, 3'h4,
                        op[6], op[5], ~op[4], ~op[3]};
            // RL11: I-mode memory and special
            IDN_CLS_I_MEM:
                bits = {1'b1, op[2], 1'b0, a.tag_modifier_nonzero,
                        ~op[4], 3'h0, op[6], op[5], ~op[1], ~op[3]};
            IDN_CLS_I_SPECIAL:
                bits = {1'b1, op[2], 1'b0, a.tag_modifier_nonzero,
                        op[9], 3'h1, op[7], op[8], ~op[1], ~op[3]};
            default: bits = 12'h000;
        endcase
        // RL21: block select override
        if (a.force_upper) begin
            bits[1] = 1'b1;
        end
    end

    // RL7: precision bit on top
    assign a.table_addr = {a.dbl_precision_key_low, bits};

endmodule : idn_addr_gen

`default_nettype wire

// ### src/idn_decode.sv
// Instruction decode stage: decode table lookup, register tracking, loading
// Summary of operation
// RL1: Table holds 8K words of 20 bits: entry, six controls, parity.
// RL2: Opcode latched from bus at end of stage 3; results at end of 4.
// RL3: Entry point used in stage 5 unless multi-step or address help.
// RL4: Base, index addresses and address type registered at end of stage 4.
// RL5: Table address formed in stage 3, read in 4, entry registered then.
// RL6: Each instruction class lands in its own fixed table range.
// RL7: Table address is twelve generated bits plus the precision bit.
// RL8: Generic address is 0, opcode 2, then opcode bits 7 to 16.
// RL9: Shift, skip and register generic address patterns per class.
// RL10: S/R and V memory address pattern with gated bits.
// RL11: I-mode memory and special pattern with tag-modifier test.
// RL12: Gated bits 13, 14 zero when part of short displacement.
// RL13: Precision key low is zero exactly when double key set.
// RL14: Control 1 gives generic length, zero for memory references.
// RL15: Control 2 flags pointer generic or requests address plus two.
// RL16: Control 3 low for branches, meaning no branch cache use.
// RL17: Controls 4-5 name the modified register for collisions.
// RL18: Destination register from opcode 7-9; odd variant forces the low bit to 1.
// RL19: Control 6 goes to address unit for exponent tracking.
// RL20: Load covers lower then upper 4K by the double key.
// RL21: Diagnostic block select forces address bit 1 for upper 2K.
// RL22: Load address from bus at stage 8, 20-bit data, one write.
// RL23: Diagnostic processor supplies table contents and addresses.
// RL24: Table write only during load steps, never during decode.
`default_nettype none

module idn_decode
    import idn_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:`IDN_OP_W] internal_bus_two,
    input wire logic [2:0] instr_class,
    input wire logic short_mem_fmt,
    input wire logic mode_32i,
    input wire logic dbl_key,
    input wire logic stage3_end,
    input wire logic stage4_end,
    input wire logic beat_phase_eight_edge,
    input wire logic eu_multi_step,
    input wire logic needs_ea_help,
    input wire logic load_step,
    input wire logic upper_block_select,
    input wire logic [`IDN_BUS_HALF_W-1:0] data_bus_high,
    input wire logic [`IDN_BUS_HALF_W-1:0] data_bus_low,
    output logic [`IDN_ENTRY_W-1:0] entry_point,
    output logic entry_point_select,
    output logic ctl_out_length,
    output logic ctl_out_pointer_or_inc2,
    output logic ctl_out_branch_cache_ok,
    output logic [1:0] ctl_out_reg_modified,
    output logic ctl_out_exponent_track,
    output logic parity_error,
    output logic [3:0] base_rf_addr,
    output logic [2:0] index_rf_addr,
    output logic [1:0] ea_type,
    output logic [2:0] dest_general_register,
    output logic [2:0] odd_dest_general_register,
    output logic [`IDN_ADDR_W-1:0] table_addr_bits
);

    idn_state_t st_ff;
    idn_state_t nxt_st;
    idn_addr_if aif ();
    logic table_wr;
    logic loading;
    logic [`IDN_WORD_W-1:0] rd_word;
    logic [`IDN_WORD_W-1:0] wr_word;
    logic [`IDN_ENTRY_W-1:0] rd_entry;
    logic [1:`IDN_CTL_W] rd_ctl;
    logic [`IDN_PAR_W-1:0] rd_par;
    logic is_i_mode;
    logic reg_to_reg;

    // Base register file address for 32I register-to-register forms
    function automatic logic [3:0] reg_base_sel(input logic [4:0] sel);
        logic [3:0] r;
        r = `IDN_BASE_PB;
        if (sel == `IDN_FLR0_SEL) begin
            r = `IDN_BASE_FLR0;
        end else if (sel == `IDN_FLR1_SEL) begin
            r = `IDN_BASE_FLR1;
        end else if (sel[1:0] == 2'h0) begin
            r = {1'b0, sel[4:2]};
        end
        return r;
    endfunction : reg_base_sel

    // Even parity per field: bit 0 over entry, bit 1 over controls
    function automatic logic [1:0] calc_parity(input logic [11:0] e,
                                               input logic [5:0] c);
        return {^c, ^e};
    endfunction : calc_parity

    // RL24: load step only
    assign loading = load_step;
    // RL22: stage 8 write
    assign table_wr = loading & beat_phase_eight_edge;
    assign wr_word = {data_bus_high, data_bus_low};

    // RL20: load maps as generic
    // Load shares the one generator: no decode step runs during a load
    assign aif.opcode = loading ? internal_bus_two : st_ff.opcode_ff;
    assign aif.cls = loading ? IDN_CLS_GENERIC : st_ff.cls_ff;
    assign aif.dbl_key = loading ? dbl_key : st_ff.dbl_key_ff;
    assign aif.short_fmt = loading ? 1'b0 : st_ff.short_fmt_ff;
    // RL21: override on load only
    assign aif.force_upper = loading & upper_block_select;

    idn_addr_gen u_addr_gen (
        .a (aif.gen)
    );

    // RL1: 8K by 20 store
    idn_table_mem u_table (
        .ref_clk (ref_clk),
        .wr_en (table_wr),
        .addr (aif.table_addr),
        .wr_data (wr_word),
        .rd_data_ff (rd_word)
    );

    assign rd_entry = rd_word[`IDN_ENTRY_LSB +: `IDN_ENTRY_W];
    assign rd_ctl = rd_word[`IDN_CTL_LSB +: `IDN_CTL_W];
    assign rd_par = rd_word[`IDN_PAR_LSB +: `IDN_PAR_W];
    assign is_i_mode = (st_ff.cls_ff == IDN_CLS_I_MEM) ||
                       (st_ff.cls_ff == IDN_CLS_I_SPECIAL);
    assign reg_to_reg = is_i_mode & st_ff.mode_32i_ff &
                        ~aif.tag_modifier_nonzero;

    always_comb begin
        nxt_st = st_ff;
        // RL2: latch at stage 3 end
        if (stage3_end) begin
            nxt_st.opcode_ff = internal_bus_two;
            nxt_st.cls_ff = idn_class_t'(instr_class);
            nxt_st.dbl_key_ff = dbl_key;
            nxt_st.short_fmt_ff = short_mem_fmt;
            nxt_st.mode_32i_ff = mode_32i;
            nxt_st.entry_valid_ff = 1'b0;
        end
        // RL5: register entry at stage 4 end
        if (stage4_end && !loading) begin
            nxt_st.entry_valid_ff = 1'b1;
            nxt_st.entry_ff = rd_entry;
            // RL14: controls straight from table
            nxt_st.ctl_ff = rd_ctl;
            nxt_st.parity_err_ff =
                calc_parity(rd_entry, rd_ctl) != rd_par;
            // RL4: register file addresses
            nxt_st.base_ff = reg_to_reg ?
                reg_base_sel(st_ff.opcode_ff[12:16]) : `IDN_BASE_PB;
            if (is_i_mode) begin
                nxt_st.index_ff = st_ff.opcode_ff[12:14];
            end else begin
                nxt_st.index_ff = st_ff.opcode_ff[2] ?
                    `IDN_IDX_X : `IDN_IDX_Y;
            end
            case (st_ff.cls_ff)
                IDN_CLS_SR_MEM: nxt_st.ea_ff = IDN_EA_SRV;
                IDN_CLS_V_MEM: nxt_st.ea_ff = IDN_EA_SRV;
                IDN_CLS_I_MEM: nxt_st.ea_ff = IDN_EA_I;
                IDN_CLS_I_SPECIAL: nxt_st.ea_ff = IDN_EA_I;
                default: nxt_st.ea_ff = IDN_EA_NONE;
            endcase
            // RL18: destination selects
            nxt_st.dest_gr_ff = st_ff.opcode_ff[7:9];
            nxt_st.odd_gr_ff = {st_ff.opcode_ff[7:8], 1'b1};
        end
        if (!rst_n) begin
            nxt_st = '0;
            nxt_st.entry_ff = `IDN_ENTRY_RST;
            nxt_st.ctl_ff = `IDN_CTL_RST;
            nxt_st.base_ff = `IDN_BASE_PB;
            nxt_st.index_ff = `IDN_IDX_Y;
        end
    end

    always_ff @(posedge ref_clk) begin
        st_ff <= nxt_st;
    end

    // RL3: stage 5 entry point use
    assign entry_point_select = st_ff.entry_valid_ff & ~eu_multi_step &
                                ~needs_ea_help;
    assign entry_point = st_ff.entry_ff;
    // RL14, RL15: length, pointer or increment
    assign ctl_out_length = st_ff.ctl_ff[1];
    assign ctl_out_pointer_or_inc2 = st_ff.ctl_ff[2];
    // RL16: branch cache permission
    assign ctl_out_branch_cache_ok = st_ff.ctl_ff[3];
    // RL17: modified register code
    assign ctl_out_reg_modified = st_ff.ctl_ff[4:5];
    // RL19: exponent tracking
    assign ctl_out_exponent_track = st_ff.ctl_ff[6];
    assign parity_error = st_ff.parity_err_ff;
    assign base_rf_addr = st_ff.base_ff;
    assign index_rf_addr = st_ff.index_ff;
    assign ea_type = st_ff.ea_ff;
    assign dest_general_register = st_ff.dest_gr_ff;
    assign odd_dest_general_register = st_ff.odd_gr_ff;
    assign table_addr_bits = aif.table_addr;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_WR_ONLY_LOAD: assert property ( // RL24
        table_wr |-> load_step && beat_phase_eight_edge)
        else $error("table written outside a load step");
    AST_OPCODE_LATCH: assert property ( // RL2
        stage3_end |=> st_ff.opcode_ff == $past(internal_bus_two))
        else $error("opcode not latched at stage 3 end");
    AST_ENTRY_CAPTURE: assert property ( // RL5
        stage4_end && !loading |=> entry_point == $past(rd_entry)
            && entry_point_select == (!eu_multi_step && !needs_ea_help))
        else $error("entry point not captured at stage 4 end");
    AST_PREC_LOW: assert property ( // RL13
        aif.dbl_precision_key_low != aif.dbl_key)
        else $error("precision key low not inverse of key");
    AST_TOP_BIT: assert property ( // RL7
        table_addr_bits[`IDN_ADDR_W-1] == ~aif.dbl_key)
        else $error("top table address bit not precision bit");
    AST_GENERIC_RANGE: assert property ( // RL8
        aif.cls == IDN_CLS_GENERIC && !aif.force_upper
            |-> table_addr_bits[11] == 1'b0
            && table_addr_bits[9:0] == aif.opcode[7:16])
        else $error("generic address pattern wrong");
    AST_GATED_ZERO: assert property ( // RL12
        aif.short_fmt |-> !aif.gated_op_bit13 && !aif.gated_op_bit14)
        else $error("gated bits not forced to zero");
    AST_UPPER_BLOCK: assert property ( // RL21
        loading && upper_block_select |-> table_addr_bits[11])
        else $error("block select did not force address bit 1");
    AST_ODD_DEST: assert property ( // RL18
        stage4_end && !loading |=> odd_dest_general_register[0]
            && odd_dest_general_register[2:1] == dest_general_register[2:1])
        else $error("odd destination register select wrong");
    AST_SHIFT_PAT: assert property ( // RL9
        aif.cls == IDN_CLS_SHIFT && !loading
            |-> table_addr_bits[11:8] == 4'he
            && table_addr_bits[3:2] == aif.opcode[7:8])
        else $error("shift address pattern wrong");
    // Remaining class patterns; a load step maps as generic instead
    AST_SKIP_PAT: assert property ( // RL9
        aif.cls == IDN_CLS_SKIP && !loading
            |-> table_addr_bits[11:8] == 4'ha
            && table_addr_bits[3:2] == aif.opcode[13:14])
        else $error("skip address pattern wrong");
    AST_REGGEN_PAT: assert property ( // RL9
        aif.cls == IDN_CLS_REG_GENERIC && !loading
            |-> table_addr_bits[11:8] == {1'b1, aif.opcode[2], 2'h3})
        else $error("register generic address pattern wrong");
    AST_SR_PAT: assert property ( // RL10
        aif.cls == IDN_CLS_SR_MEM && !loading
            |-> table_addr_bits[11:9] == {1'b1, aif.opcode[2], 1'b0}
            && table_addr_bits[6:4] == {~aif.dbl_key, 2'h2}
            && table_addr_bits[1:0] == {~aif.opcode[4], ~aif.opcode[3]})
        else $error("S/R memory address pattern wrong");
    AST_V_PAT: assert property ( // RL10
        aif.cls == IDN_CLS_V_MEM && !loading
            |-> table_addr_bits[6:4] == 3'h4
            && table_addr_bits[3:2] == {aif.opcode[6], aif.opcode[5]})
        else $error("V memory address pattern wrong");
    AST_I_PAT: assert property ( // RL11
        (aif.cls == IDN_CLS_I_MEM || aif.cls == IDN_CLS_I_SPECIAL)
            && !loading |-> table_addr_bits[9] == 1'b0
            && table_addr_bits[8] == (aif.opcode[10] | aif.opcode[11])
            && table_addr_bits[1:0] == {~aif.opcode[1], ~aif.opcode[3]})
        else $error("I-mode address pattern wrong");
    AST_CAPTURE_CTL: assert property ( // RL14
        stage4_end && !loading |=> {ctl_out_length, ctl_out_pointer_or_inc2,
            ctl_out_branch_cache_ok, ctl_out_reg_modified,
            ctl_out_exponent_track} == $past(rd_ctl))
        else $error("control bits not captured at stage 4 end");
    AST_SEL_DROP: assert property ( // RL3
        stage3_end && !stage4_end |=> !entry_point_select)
        else $error("entry point select held past a new opcode");
    AST_INDEX: assert property ( // RL4
        stage4_end && !loading && !stage3_end && !is_i_mode
            |=> index_rf_addr == (st_ff.opcode_ff[2] ?
                `IDN_IDX_X : `IDN_IDX_Y))
        else $error("index register select wrong");
    AST_BASE_PB: assert property ( // RL4
        stage4_end && !loading && !reg_to_reg
            |=> base_rf_addr == `IDN_BASE_PB)
        else $error("base register not forced to PB");
    AST_EA_TYPE: assert property ( // RL4
        stage4_end && !loading && !stage3_end
            |=> (ea_type == 2'h2) == is_i_mode)
        else $error("I-mode address type wrong");
    AST_DEST: assert property ( // RL18
        stage4_end && !loading && !stage3_end
            |=> dest_general_register == st_ff.opcode_ff[7:9])
        else $error("destination register select wrong");
    AST_LOAD_ADDR: assert property ( // RL22
        table_wr |-> table_addr_bits[12] == ~dbl_key
            && table_addr_bits[11:0] == {upper_block_select,
            internal_bus_two[2], internal_bus_two[7:16]})
        else $error("load address not mapped as generic");
    AST_GATED_PASS: assert property ( // RL12
        !aif.short_fmt |-> aif.gated_op_bit13 == aif.opcode[13]
            && aif.gated_op_bit14 == aif.opcode[14])
        else $error("gated bits differ from opcode");

    COV_DECODE: cover property (
        stage3_end ##[1:8] stage4_end ##1 entry_point_select);
    COV_LOAD_UPPER: cover property (table_wr && upper_block_select);
    COV_PARITY: cover property (parity_error);
    COV_HELD: cover property (st_ff.entry_valid_ff && !entry_point_select);

endmodule : idn_decode

`default_nettype wire

// ### src/idn_table_mem.sv
// Decode table storage, one write port, registered read
`default_nettype none

module idn_table_mem
    import idn_pkg::*;
(
    input wire logic ref_clk,
    input wire logic wr_en,
    input wire logic [`IDN_ADDR_W-1:0] addr,
    input wire logic [`IDN_WORD_W-1:0] wr_data,
    output logic [`IDN_WORD_W-1:0] rd_data_ff
);

    logic [`IDN_WORD_W-1:0] mem [0:`IDN_DEPTH-1];

    // Contents are undefined until loaded; no reset on the array
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
        rd_data_ff <= mem[addr];
    end

endmodule : idn_table_mem

`default_nettype wire

// ### verification/idn_dp_model.sv
// Diagnostic processor model that loads decode table words
`default_nettype none
module idn_dp_model (
    input wire logic ref_clk,
    output logic load_step,
    output logic beat_phase_eight_edge,
    output logic upper_block_select,
    output logic dbl_key,
    output logic [1:16] bus,
    output logic [9:0] data_high,
    output logic [9:0] data_low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        load_step = 1'b0;
        beat_phase_eight_edge = 1'b0;
        upper_block_select = 1'b0;
        dbl_key = 1'b0;
        bus = 16'h0;
        {data_high, data_low} = 20'h0;
    end
    task automatic put(input logic [12:0] a, input logic [19:0] w,
                       input logic step);
        @(posedge ref_clk);
        #1;
        dbl_key = ~a[12];
        upper_block_select = a[11];
        bus = 16'h0;
        bus[2] = a[10];
        bus[7:16] = a[9:0];
        {data_high, data_low} = w;
        load_step = step;
        beat_phase_eight_edge = 1'b1;
        @(posedge ref_clk);
        #1;
        load_step = 1'b0;
        beat_phase_eight_edge = 1'b0;
        upper_block_select = 1'b0;
        // Released lines must not keep showing the last word
        {data_high, data_low} = ~w;
        bus = ~bus;
    endtask : put
endmodule : idn_dp_model
`default_nettype wire

// ### verification/tb_instruction_decode_net.sv
// Self-checking bench for the instruction decode stage
`default_nettype none
module tb_instruction_decode_net;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_n, s3, s4, ld, p8, up, dp_dbl, tb_dbl, dbl_in;
    logic short_fmt, m32, multi, help, sel, c_len, c_ptr, c_br, c_exp, par;
    logic [2:0] cls, idx, dest, odd;
    logic [1:16] tb_bus, dp_bus, bus_in;
    logic [9:0] dh, dl;
    logic [11:0] entry_point;
    logic [1:0] c_reg, ea;
    logic [3:0] base;
    logic [12:0] taddr, seen_addr;
    int errors, total_checks, cycles;
    assign bus_in = ld ? dp_bus : tb_bus;
    assign dbl_in = ld ? dp_dbl : tb_dbl;
    always #2.5 ref_clk = ~ref_clk;

    idn_dp_model dp (.ref_clk(ref_clk), .load_step(ld),
        .beat_phase_eight_edge(p8), .upper_block_select(up),
        .dbl_key(dp_dbl), .bus(dp_bus), .data_high(dh), .data_low(dl));

    idn_decode uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .internal_bus_two(bus_in), .instr_class(cls),
        .short_mem_fmt(short_fmt), .mode_32i(m32), .dbl_key(dbl_in),
        .stage3_end(s3), .stage4_end(s4), .beat_phase_eight_edge(p8),
        .eu_multi_step(multi), .needs_ea_help(help), .load_step(ld),
        .upper_block_select(up), .data_bus_high(dh), .data_bus_low(dl),
        .entry_point(entry_point), .entry_point_select(sel),
        .ctl_out_length(c_len), .ctl_out_pointer_or_inc2(c_ptr),
        .ctl_out_branch_cache_ok(c_br), .ctl_out_reg_modified(c_reg),
        .ctl_out_exponent_track(c_exp), .parity_error(par),
        .base_rf_addr(base), .index_rf_addr(idx), .ea_type(ea),
        .dest_general_register(dest), .odd_dest_general_register(odd),
        .table_addr_bits(taddr));

    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    function automatic logic [12:0] exp_addr(input logic [1:16] o,
        input logic [2:0] c, input logic d, input logic s);
        logic tm, g13, g14;
        logic [11:0] a;
        tm = o[10] | o[11];
        g13 = o[13] & ~s;
        g14 = o[14] & ~s;
        case (c)
            3'h0: a = {1'b0, o[2], o[7:16]};
            3'h1: a = {4'he, o[9:12], o[7:8], o[15:16]};
            3'h2: a = {4'ha, o[9:16]};
            3'h3: a = {1'b1, o[2], 2'h3, o[9:16]};
            3'h4: a = {1'b1, o[2], 1'b0, g13, g14, ~d, 2'h2, o[6], o[5],
                       ~o[4], ~o[3]};
            3'h5: a = {1'b1, o[2], 1'b0, g13, g14, 3'h4, o[6], o[5],
                       ~o[4], ~o[3]};
            3'h6: a = {1'b1, o[2], 1'b0, tm, ~o[4], 3'h0, o[6], o[5],
                       ~o[1], ~o[3]};
            default: a = {1'b1, o[2], 1'b0, tm, o[9], 3'h1, o[7], o[8],
                          ~o[1], ~o[3]};
        endcase
        return {~d, a};
    endfunction : exp_addr

    // Parity bits are chosen good unless bad flips the control parity
    function automatic logic [19:0] mkw(input logic [11:0] e,
        input logic [5:0] c, input logic bad);
        return {(^c) ^ bad, ^e, c, e};
    endfunction : mkw

    task automatic decode(input logic [1:16] o, input logic [2:0] c,
        input logic d, input logic s, input logic m);
        @(posedge ref_clk);
        #1;
        tb_bus = o;
        cls = c;
        tb_dbl = d;
        short_fmt = s;
        m32 = m;
        s3 = 1'b1;
        @(posedge ref_clk);
        #1;
        s3 = 1'b0;
        tb_bus = ~o;
        @(posedge ref_clk);
        #1;
        seen_addr = taddr;
        s4 = 1'b1;
        @(posedge ref_clk);
        #1;
        s4 = 1'b0;
    endtask : decode

    task automatic t_reset();
        chk({entry_point, sel, par, base, ea}, {14'h0, 4'hc, 2'h0});
        chk({5'h0, c_len, c_ptr, c_br, c_reg, c_exp, idx, dest, odd},
            {11'h0, 3'h5, 6'h0});
    endtask : t_reset

    task automatic t_addr_map();
        logic [3:0] c, k;
        logic [1:16] o;
        logic [2:0] ei;
        logic [1:0] ee;
        logic [12:0] xa;
        for (c = 4'h0; c < 4'h8; c++) begin
            for (k = 4'h0; k < 4'h8; k++) begin
                o = 16'ha5c3 ^ {k, c, ~k, c};
                decode(o, c[2:0], k[2], k[0], 1'b0);
                ee = c[2] ? (c[1] ? 2'h2 : 2'h1) : 2'h0;
                ei = (c[2] & c[1]) ? o[12:14] : (o[2] ? 3'h7 : 3'h5);
                xa = exp_addr(o, c[2:0], k[2], k[0]);
                chk({7'h0, seen_addr},
                    {7'h0, xa});
                chk({5'h0, base, idx, ea, dest, odd}, {5'h0, 4'hc, ei, ee,
                    o[7:9], o[7:8], 1'b1});
                chk({1'b0, par, c_len, c_ptr, c_br, c_reg, c_exp,
                    entry_point}, {2'h0, xa[12], xa[4:0],
                    xa[11:0]});
            end
        end
    endtask : t_addr_map

    task automatic t_base32();
        decode(16'h0006, 3'h6, 1'b0, 1'b0, 1'b1);
        chk({16'h0, base}, 20'h9);
    endtask : t_base32

    task automatic t_load();
        logic [12:0] a [4];
        logic [19:0] w [4];
        a = '{13'h1123, 13'h1b23, 13'h0123, 13'h0b23};
        w = '{mkw(12'h5a7, 6'h2d, 1'b0), mkw(12'ha58, 6'h12, 1'b0),
              mkw(12'hfff, 6'h3f, 1'b0), mkw(12'h001, 6'h20, 1'b1)};
        for (int i = 0; i < 4; i++) dp.put(a[i], w[i], 1'b1);
        for (int i = 0; i < 4; i++) begin
            decode(16'h0123, i[0] ? 3'h3 : 3'h0, i[1], 1'b0, 1'b0);
            chk({7'h0, seen_addr}, {7'h0, a[i]});
            chk({8'h0, entry_point}, {8'h0, w[i][11:0]});
            chk({13'h0, c_len, c_ptr, c_br, c_reg, c_exp, par},
                {13'h0, w[i][17:12], i == 3});
        end
    endtask : t_load

    // A pulse outside a load step must leave the table untouched
    task automatic t_stray();
        dp.put(13'h1123, mkw(12'h0f0, 6'h00, 1'b0), 1'b0);
        decode(16'h0123, 3'h0, 1'b0, 1'b0, 1'b0);
        chk({8'h0, entry_point}, 20'h5a7);
    endtask : t_stray

    task automatic t_select();
        chk({19'h0, sel}, 20'h1);
        multi = 1'b1;
        @(posedge ref_clk);
        #1;
        chk({19'h0, sel}, 20'h0);
        multi = 1'b0;
        help = 1'b1;
        @(posedge ref_clk);
        #1;
        chk({19'h0, sel}, 20'h0);
        help = 1'b0;
    endtask : t_select

    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        {s3, s4, tb_dbl, short_fmt, m32, multi, help} = 7'h0;
        cls = 3'h0;
        tb_bus = 16'h0;
        repeat (8) @(posedge ref_clk);
        #1;
        t_reset();
        rst_n = 1'b1;
        // whole table load
        // Unloaded words would feed unknowns into every capture
        for (int i = 0; i < 8192; i++) begin
            dp.put(i[12:0], mkw(i[11:0], {i[12], i[4:0]}, 1'b0), 1'b1);
        end
        t_addr_map();
        t_base32();
        t_load();
        t_stray();
        t_select();
        wrap_up();
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end
endmodule : tb_instruction_decode_net
`default_nettype wire
